// [rtl/mlc_pkg.sv]
package mlc_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'h7FFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam int unsigned OUT_W = 8;
  localparam logic [11:0] ADDR_PORT1 = 12'h000;
  localparam logic [11:0] ADDR_PORT2 = 12'h004;
  localparam logic [11:0] ADDR_PORT3 = 12'h008;
  localparam logic [11:0] ADDR_WLAN = 12'h00C;
  localparam logic [11:0] ADDR_CTRL = 12'h010;
  localparam logic [11:0] ADDR_OUTREQ = 12'h014;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h018;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h01C;
  localparam logic [11:0] ADDR_LIMIT = 12'h020;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_SOFT_CLR_BIT = 1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [15:0] LIMIT_RESET = 16'h003C;
endpackage : mlc_pkg

// [rtl/mlc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module mlc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s1_nxt;
  logic s2_r;
  logic s2_nxt;
  // First stage feeds only the second
  always_comb begin
    s1_nxt = clk_en ? din : s1_r;
    s2_nxt = clk_en ? s1_r : s2_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end
  assign dout = s2_r;
endmodule : mlc_sync
`default_nettype wire

// [rtl/mlc_silence_cnt.sv]
`timescale 1ns/1ps
`default_nettype none
module mlc_silence_cnt #(
  parameter int unsigned W = mlc_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic msg_seen,
  input wire logic sec_tick,
  output logic [W-1:0] count
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (clk_en) begin
      if (msg_seen) begin
        cnt_nxt = W'(mlc_pkg::CNT_RESET); // [R2]
      end else if (sec_tick && cnt_r != mlc_pkg::CNT_MAX) begin
        cnt_nxt = W'(cnt_r + 1'b1); // [R3] [R5]
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= W'(mlc_pkg::CNT_RESET);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign count = cnt_r;

  AST_SATURATE: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_r == mlc_pkg::CNT_MAX && !msg_seen) |=> cnt_r == mlc_pkg::CNT_MAX) // [R5]
    else $error("counter left maximum without a message");
  AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && msg_seen) |=> cnt_r == mlc_pkg::CNT_RESET) // [R2]
    else $error("counter not cleared by message");
  AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sec_tick && !msg_seen && cnt_r != mlc_pkg::CNT_MAX)
      |=> cnt_r == $past(cnt_r) + 1'b1) // [R3]
    else $error("counter did not advance on tick");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!sec_tick && !msg_seen) |=> $stable(cnt_r)) // [R3]
    else $error("counter moved without a tick");
endmodule : mlc_silence_cnt
`default_nettype wire

// [rtl/mlc_top.sv]
// Behaviour
// R1: One silence counter per port, four total
// R2: Master message clears only that port's counter
// R3: Counter advances one per second afterwards
// R4: Counter value equals seconds of silence
// R5: Counter saturates at 32767 until cleared
// R6: Requests served without any loaded program
// R7: Outputs held off unless in run state
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mlc_top #(
  parameter int unsigned TICK_CYCLES = mlc_pkg::TICK_CYCLES,
  parameter int unsigned NPORT = mlc_pkg::NUM_PORTS,
  parameter int unsigned OUT_W = mlc_pkg::OUT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPORT-1:0] master_msg,
  input wire logic [OUT_W-1:0] master_out_req,
  input wire logic program_loaded,
  output logic [OUT_W-1:0] out_points,
  output logic serve_enable,
  output logic irq
);
  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic [NPORT-1:0] msg_lvl;
  logic [NPORT-1:0] msg_prev_r;
  logic [NPORT-1:0] msg_prev_nxt;
  logic [NPORT-1:0] msg_pulse;
  logic [mlc_pkg::CNT_W-1:0] cnt [NPORT];
  logic [TW-1:0] tick_r;
  logic [TW-1:0] tick_nxt;
  logic sec_tick;

  // Message strobes come from other clock domains
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      mlc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .din(master_msg[gi]),
        .dout(msg_lvl[gi])
      );
      mlc_silence_cnt u_cnt ( // [R1] [R4]
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .msg_seen(msg_pulse[gi]),
        .sec_tick(sec_tick),
        .count(cnt[gi])
      );
    end
  endgenerate

  // Rising edge counts as one received message
  assign msg_pulse = msg_lvl & ~msg_prev_r;
  assign sec_tick = clk_en && (tick_r == TICK_LAST);

  always_comb begin
    msg_prev_nxt = clk_en ? msg_lvl : msg_prev_r;
    tick_nxt = tick_r;
    if (clk_en) begin
      tick_nxt = (tick_r == TICK_LAST) ? '0 : TW'(tick_r + 1'b1); // [R3]
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_prev_r <= '0;
      tick_r <= '0;
    end else begin
      msg_prev_r <= msg_prev_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Register state
  logic run_r;
  logic run_nxt;
  logic [OUT_W-1:0] outreq_r;
  logic [OUT_W-1:0] outreq_nxt;
  logic [OUT_W-1:0] outp_r;
  logic [OUT_W-1:0] outp_nxt;
  logic [NPORT-1:0] stat_r;
  logic [NPORT-1:0] stat_nxt;
  logic [NPORT-1:0] mask_r;
  logic [NPORT-1:0] mask_nxt;
  logic [15:0] limit_r;
  logic [15:0] limit_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic irq_r;
  logic irq_nxt;
  logic serve_r;
  logic [NPORT-1:0] limit_hit;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;

  assign wr_acc = clk_en && psel && penable && pwrite;
  assign rd_acc = clk_en && psel && !penable && !pwrite;

  always_comb begin
    case (paddr)
      mlc_pkg::ADDR_PORT1,
      mlc_pkg::ADDR_PORT2,
      mlc_pkg::ADDR_PORT3,
      mlc_pkg::ADDR_WLAN,
      mlc_pkg::ADDR_CTRL,
      mlc_pkg::ADDR_OUTREQ,
      mlc_pkg::ADDR_IRQ_STAT,
      mlc_pkg::ADDR_IRQ_MASK,
      mlc_pkg::ADDR_LIMIT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Event fires once, as the counter reaches the limit; a limit of 0x8000 fires on every tick once the counter saturates at 0x7FFF
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_lim
      assign limit_hit[gi] = sec_tick && !msg_pulse[gi] && limit_r != '0 &&
        (cnt[gi] == 16'(limit_r - 1'b1));
    end
  endgenerate

  always_comb begin
    run_nxt = run_r;
    outreq_nxt = outreq_r;
    mask_nxt = mask_r;
    limit_nxt = limit_r;
    stat_nxt = stat_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (wr_acc && addr_ok) begin
      case (paddr)
        mlc_pkg::ADDR_CTRL: run_nxt = pwdata[mlc_pkg::CTRL_RUN_BIT];
        mlc_pkg::ADDR_OUTREQ: outreq_nxt = pwdata[OUT_W-1:0];
        mlc_pkg::ADDR_IRQ_MASK: mask_nxt = pwdata[NPORT-1:0];
        mlc_pkg::ADDR_LIMIT: limit_nxt = pwdata[15:0];
        mlc_pkg::ADDR_IRQ_STAT: stat_nxt = stat_r & ~pwdata[NPORT-1:0];
        default: run_nxt = run_r;
      endcase
    end
    if (clk_en) begin
      stat_nxt = stat_nxt | limit_hit;
    end
    if (rd_acc) begin
      case (paddr)
        mlc_pkg::ADDR_PORT1: prdata_nxt = {16'h0000, cnt[0]};
        mlc_pkg::ADDR_PORT2: prdata_nxt = {16'h0000, cnt[1]};
        mlc_pkg::ADDR_PORT3: prdata_nxt = {16'h0000, cnt[2]};
        mlc_pkg::ADDR_WLAN: prdata_nxt = {16'h0000, cnt[3]};
        mlc_pkg::ADDR_CTRL: prdata_nxt = {31'h0000_0000, run_r};
        mlc_pkg::ADDR_OUTREQ: prdata_nxt = 32'(outreq_r);
        mlc_pkg::ADDR_IRQ_STAT: prdata_nxt = 32'(stat_r);
        mlc_pkg::ADDR_IRQ_MASK: prdata_nxt = 32'(mask_r);
        mlc_pkg::ADDR_LIMIT: prdata_nxt = {16'h0000, limit_r};
        default: prdata_nxt = mlc_pkg::RD_ZERO;
      endcase
    end
    if (clk_en && psel && !penable) begin
      pslverr_nxt = !addr_ok;
    end
    // Software and master requests are merged, then gated by run
    outp_nxt = outp_r;
    if (clk_en) begin
      outp_nxt = run_r ? (outreq_r | master_out_req) : '0; // [R7]
    end
    irq_nxt = clk_en ? |(stat_nxt & mask_nxt) : irq_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      outreq_r <= '0;
      outp_r <= '0;
      stat_r <= '0;
      mask_r <= '0;
      limit_r <= mlc_pkg::LIMIT_RESET;
      prdata_r <= mlc_pkg::RD_ZERO;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      serve_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      outreq_r <= outreq_nxt;
      outp_r <= outp_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      limit_r <= limit_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      // Serving does not depend on a loaded program
      serve_r <= 1'b1; // [R6]
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;
  assign out_points = outp_r;
  assign serve_enable = serve_r;
  assign irq = irq_r;

  sequence s_not_run;
    !run_r;
  endsequence
  sequence s_outputs_off;
    out_points == '0;
  endsequence

  AST_OFF_NOT_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (s_not_run ##1 s_not_run) |-> s_outputs_off) // [R7]
    else $error("outputs on while not running");
  AST_SERVE_ALWAYS: assert property (@(posedge pclk) disable iff (!presetn)
    (!program_loaded ##1 1'b1) |-> serve_enable) // [R6]
    else $error("serving stopped without program");
  AST_PORT_INDEP: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && msg_pulse[0] && !msg_pulse[1] && !sec_tick) |=> $stable(cnt[1])) // [R2]
    else $error("other port counter disturbed");
  AST_TICK_GAP: assert property (@(posedge pclk) disable iff (!presetn)
    sec_tick |=> !sec_tick) // [R3]
    else $error("second ticks back to back");
  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> irq == |(stat_r & mask_r))
    else $error("interrupt does not follow status and mask");
endmodule : mlc_top
`default_nettype wire

// [testbench/mlc_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mlc_master_model (
  input wire logic pclk,
  input wire logic [3:0] send,
  output logic [3:0] master_msg
);
  // Random hold length varies where the falling edge lands against the synchroniser
  initial master_msg = 4'h0;
  for (genvar i = 0; i < 4; i++) begin : g_port
    always @(posedge pclk) begin
      if (send[i] && !master_msg[i]) begin
        master_msg[i] <= 1'b1;
        repeat (3 + $urandom_range(3)) @(posedge pclk);
        master_msg[i] <= 1'b0;
      end
    end
  end
endmodule : mlc_master_model
`default_nettype wire

// [testbench/mlc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mlc_top_tb;
  localparam int unsigned TK = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, serve_enable, irq, err, a;
  logic program_loaded = 1'b0;
  logic [3:0] send = 4'h0;
  logic [3:0] master_msg;
  logic [7:0] master_out_req = 8'h00;
  logic [7:0] out_points, oreq;
  logic [15:0] v [4];
  logic [15:0] w [4];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 pclk = ~pclk;
  mlc_top #(.TICK_CYCLES(TK)) mlc_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_msg(master_msg),
    .master_out_req(master_out_req), .program_loaded(program_loaded),
    .out_points(out_points), .serve_enable(serve_enable), .irq(irq));
  mlc_master_model mlc_master_model_inst (.pclk(pclk), .send(send), .master_msg(master_msg));
  task automatic end_sim;
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_all;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      v[i] = rd[15:0];
    end
  endtask : rd_all
  task automatic msg(input int i);
    @(posedge pclk);
    send <= 4'h1 << i;
    @(posedge pclk);
    send <= 4'h0;
    repeat (8) @(posedge pclk);
  endtask : msg
  initial begin
    void'($urandom(32'hD00FB7B6));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, mlc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    chk("slverr_ok", 32'h0, 32'(err));
    apb(1'b0, mlc_pkg::ADDR_LIMIT, 32'h0);
    chk("limit", 32'h3C, rd);
    apb(1'b0, mlc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat", 32'h0, rd);
    apb(1'b1, mlc_pkg::ADDR_LIMIT, 32'h1E);
    repeat (60) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      rd_all();
      w = v;
      msg(i);
      rd_all();
      for (int j = 0; j < 4; j++) begin
        if (j == i) chk("cleared", 32'h1, 32'(v[j] <= 12 && w[j] > 12));
        else chk("untouched", 32'h1, 32'(v[j] > w[j]));
      end
    end
    apb(1'b0, mlc_pkg::ADDR_PORT2, 32'h0);
    w[0] = rd[15:0];
    repeat (20 * TK - 3) @(posedge pclk);
    apb(1'b0, mlc_pkg::ADDR_PORT2, 32'h0);
    chk("step", 32'd20, 32'(rd[15:0] - w[0]));
    msg(2);
    repeat (60 * TK) @(posedge pclk);
    apb(1'b0, mlc_pkg::ADDR_PORT3, 32'h0);
    chk("sixty", 32'h1, 32'(rd >= 60 && rd <= 68));
    program_loaded <= 1'($urandom);
    master_out_req <= 8'($urandom) | 8'h01;
    oreq = 8'($urandom);
    apb(1'b1, mlc_pkg::ADDR_OUTREQ, {24'h0, oreq});
    repeat (3) @(posedge pclk);
    chk("out_stop", 32'h0, 32'(out_points));
    chk("serve", 32'h1, 32'(serve_enable));
    apb(1'b1, mlc_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk("out_run", 32'(oreq | master_out_req), 32'(out_points));
    apb(1'b1, mlc_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("out_off", 32'h0, 32'(out_points));
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    repeat (66000) @(posedge pclk);
    rd_all();
    for (int j = 0; j < 4; j++) chk("saturate", 32'h7FFF, 32'(v[j]));
    apb(1'b1, mlc_pkg::ADDR_PORT1, 32'h0);
    repeat (40) @(posedge pclk);
    apb(1'b0, mlc_pkg::ADDR_PORT1, 32'h0);
    chk("ro_hold", 32'h7FFF, rd);
    apb(1'b0, mlc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat_set", 32'hF, rd);
    apb(1'b1, mlc_pkg::ADDR_IRQ_MASK, 32'hF);
    repeat (2) @(posedge pclk);
    a = irq;
    apb(1'b1, mlc_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_mask", 32'h1, 32'(a ^ irq));
    apb(1'b1, mlc_pkg::ADDR_IRQ_STAT, 32'h1);
    apb(1'b0, mlc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("w1c", 32'hE, rd);
    apb(1'b1, mlc_pkg::ADDR_IRQ_STAT, 32'hE);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 32'h0, 32'(irq));
    msg(0);
    apb(1'b0, mlc_pkg::ADDR_PORT1, 32'h0);
    chk("resume", 32'h1, 32'(rd <= 8));
    end_sim();
  end
endmodule : mlc_top_tb
`default_nettype wire
